// File: logic/prfn_pkg.sv
/*
  Shared constants and carriers for the peripheral request flag and
  non-maskable interrupt block: register offsets, field positions,
  reset values, priority levels and the source classes.
  Assumes a 32-bit AHB-Lite fabric with word-aligned registers.
*/
package prfn_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] PRFN_OFS_FLAGS_A  = 8'h00;
  localparam logic [7:0] PRFN_OFS_FLAGS_B  = 8'h04;
  localparam logic [7:0] PRFN_OFS_CTRL_0   = 8'h08;
  localparam logic [7:0] PRFN_OFS_CTRL_1   = 8'h0C;
  localparam logic [7:0] PRFN_OFS_PRIO     = 8'h10;
  localparam logic [7:0] PRFN_OFS_STATUS   = 8'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PRFN_A_SERIAL_TX  = 7;
  localparam int PRFN_A_SERIAL_RX  = 5;
  localparam int PRFN_A_SERIAL_ERR = 4;
  localparam int PRFN_A_DMA_HI     = 3;
  localparam int PRFN_B_ADC        = 4;
  localparam int PRFN_B_SERIAL_TX  = 3;
  localparam int PRFN_B_SERIAL_RX  = 1;
  localparam int PRFN_B_SERIAL_ERR = 0;
  localparam int PRFN_C0_POLARITY  = 0;
  localparam int PRFN_C1_REJECT    = 0;
  localparam int PRFN_C1_OVERRIDE  = 1;
  localparam int PRFN_PRIO_W       = 4;

  // ****************************************************************
  // reset values and levels
  // ****************************************************************
  localparam logic [7:0]  PRFN_FLAGS_RST = 8'h00;
  localparam logic [15:0] PRFN_PRIO_RST  = 16'h0000;
  localparam logic [4:0]  PRFN_LVL_NMI   = 5'h10;
  localparam logic [4:0]  PRFN_LVL_NONE  = 5'h00;

  typedef enum logic [2:0] {
    PRFN_SRC_NONE   = 3'h0,
    PRFN_SRC_NMI    = 3'h1,
    PRFN_SRC_IRQ    = 3'h2,
    PRFN_SRC_ENC    = 3'h3,
    PRFN_SRC_PORT   = 3'h4,
    PRFN_SRC_PERIPH = 3'h5
  } prfn_class_t;

  typedef enum logic [1:0] {
    PRFN_NMI_IDLE    = 2'b00,
    PRFN_NMI_PENDING = 2'b01,
    PRFN_NMI_TAKEN   = 2'b11
  } prfn_nmi_state_t;

  typedef struct packed {
    logic       serial_a_tx;
    logic       serial_a_rx;
    logic       serial_a_error;
    logic [3:0] dma_end;
    logic       adc_done;
    logic       serial_c_tx;
    logic       serial_c_rx;
    logic       serial_c_error;
  } prfn_periph_req_t;

  typedef struct packed {
    logic       status_block_bit;
    logic [3:0] mask_level_bits;
    logic       sleep;
    logic       standby;
  } prfn_cpu_status_t;

  typedef struct packed {
    logic [3:0] irq_level;
    logic [3:0] enc_level;
    logic [3:0] port_level;
  } prfn_ext_levels_t;

endpackage : prfn_pkg

// File: logic/prfn_top.sv
/*
  Peripheral request flags, priority resolution and the non-maskable
  interrupt path, with an AHB-Lite register slave.
  Assumes all inputs synchronous to clk_in, one slave on the bus, and
  the cpu core taking requests through the ack handshake.
*/
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Contract
// - flags a bit 7 mirrors serial a transmit request.
// - flags a bit 5 mirrors serial a receive request.
// - flags a bit 4 mirrors serial a receive error request.
// - flags a bits 3..0 mirror dma channel 3..0 end requests.
// - flags b bit 4 mirrors adc conversion done request.
// - flags b bits 3,1,0 mirror serial c tx, rx, error requests.
// - reserved flag bits always read zero.
// - both flag registers are eight bits and reset to zero.
// - five source classes: nmi, irq, encoded level, port, peripheral.
// - priorities run 0..16; 1 lowest accepted, 16 highest.
// - a source at level 0 is masked and ignored.
// - the nmi always has fixed level 16.
// - nmi accepted when override bit is 1 or status block bit 0.
// - nmi is edge detected; polarity bit picks rising or falling.
// - in sleep or standby the nmi ignores the status block bit.
// - nmi exception leaves the status mask level bits unchanged.
// - while the reject bit is 1 the nmi is not accepted.
// - a detected nmi edge wakes the chip from sleep or standby.
module prfn_top
  import prfn_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // ahb-lite slave
  input  wire logic             hsel_in,
  input  wire logic [31:0]      haddr_in,
  input  wire logic [1:0]       htrans_in,
  input  wire logic             hwrite_in,
  input  wire logic [2:0]       hsize_in,
  input  wire logic [31:0]      hwdata_in,
  input  wire logic             hready_in,
  output logic                  hreadyout_out,
  output logic                  hresp_out,
  output logic [31:0]           hrdata_out,
  // sources
  input  wire prfn_periph_req_t periph_req_in,
  input  wire prfn_ext_levels_t ext_levels_in,
  input  wire logic             nmi_pin_in,
  // cpu side
  input  wire prfn_cpu_status_t cpu_status_in,
  input  wire logic             cpu_ack_in,
  output logic                  int_req_out,
  output logic [4:0]            int_level_out,
  output prfn_class_t           int_class_out,
  output logic                  nmi_request_out,
  output logic [3:0]            exc_mask_level_out,
  output logic                  wake_out
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic [4:0] prfn_gate_level(input logic req,
                                                 input logic [3:0] lvl);
    // level 0 means masked, so a live request there is dropped
    prfn_gate_level = (req && (lvl != 4'h0)) ? {1'b0, lvl} : PRFN_LVL_NONE;
  endfunction : prfn_gate_level

  function automatic logic prfn_hit(input logic [31:0] addr,
                                    input logic [7:0] ofs);
    prfn_hit = (addr[31:2] == {24'h000000, ofs[7:2]});
  endfunction : prfn_hit

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]      peripheral_request_flags_a;
  logic [7:0]      peripheral_request_flags_b;
  logic            nmi_edge_polarity;
  logic            nmi_reject_bit;
  logic            block_override_for_nmi;
  logic [15:0]     prio;
  logic            wr_pend;
  logic [31:0]     wr_addr;
  logic            nmi_s1;
  logic            nmi_s2;
  logic            nmi_stable;
  prfn_nmi_state_t nmi_state;
  prfn_nmi_state_t next_nmi_state;
  logic            nmi_edge;
  logic            nmi_acceptable;
  logic            low_power;
  logic [4:0]      lvl_irq;
  logic [4:0]      lvl_enc;
  logic [4:0]      lvl_port;
  logic [4:0]      lvl_per;
  logic [4:0]      best_level;
  prfn_class_t     best_class;
  logic            addr_phase;
  logic [31:0]     rd_word;

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign addr_phase    = hsel_in && htrans_in[1] && hready_in;
  assign low_power     = cpu_status_in.sleep || cpu_status_in.standby;

  // ****************************************************************
  // request flag registers
  // ****************************************************************
  // flags are a registered copy of the live lines; a read lags by a cycle
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      peripheral_request_flags_a <= PRFN_FLAGS_RST;
      peripheral_request_flags_b <= PRFN_FLAGS_RST;
    end
    else
    begin
      peripheral_request_flags_a <= PRFN_FLAGS_RST;
      peripheral_request_flags_b <= PRFN_FLAGS_RST;
      peripheral_request_flags_a[PRFN_A_SERIAL_TX]  <= periph_req_in.serial_a_tx;
      peripheral_request_flags_a[PRFN_A_SERIAL_RX]  <= periph_req_in.serial_a_rx;
      peripheral_request_flags_a[PRFN_A_SERIAL_ERR] <= periph_req_in.serial_a_error;
      peripheral_request_flags_a[PRFN_A_DMA_HI:0]   <= periph_req_in.dma_end;
      peripheral_request_flags_b[PRFN_B_ADC]        <= periph_req_in.adc_done;
      peripheral_request_flags_b[PRFN_B_SERIAL_TX]  <= periph_req_in.serial_c_tx;
      peripheral_request_flags_b[PRFN_B_SERIAL_RX]  <= periph_req_in.serial_c_rx;
      peripheral_request_flags_b[PRFN_B_SERIAL_ERR] <= periph_req_in.serial_c_error;
    end
  end

  // ****************************************************************
  // bus slave: address phase capture
  // ****************************************************************
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h00000000;
    end
    else if (hready_in)
    begin
      wr_pend <= addr_phase && hwrite_in;
      wr_addr <= haddr_in;
    end
  end

  // ****************************************************************
  // bus slave: control register writes
  // ****************************************************************
  // flag registers have no write path at all, so writes there are lost
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      nmi_edge_polarity      <= 1'b0;
      nmi_reject_bit         <= 1'b0;
      block_override_for_nmi <= 1'b0;
      prio                   <= PRFN_PRIO_RST;
    end
    else if (wr_pend)
    begin
      if (prfn_hit(wr_addr, PRFN_OFS_CTRL_0))
      begin
        nmi_edge_polarity <= hwdata_in[PRFN_C0_POLARITY];
      end
      if (prfn_hit(wr_addr, PRFN_OFS_CTRL_1))
      begin
        nmi_reject_bit         <= hwdata_in[PRFN_C1_REJECT];
        block_override_for_nmi <= hwdata_in[PRFN_C1_OVERRIDE];
      end
      if (prfn_hit(wr_addr, PRFN_OFS_PRIO))
      begin
        prio <= hwdata_in[15:0];
      end
    end
  end

  // ****************************************************************
  // bus slave: read data
  // ****************************************************************
  always_comb
  begin
    rd_word = 32'h00000000;
    if (prfn_hit(haddr_in, PRFN_OFS_FLAGS_A))
    begin
      rd_word[7:0] = peripheral_request_flags_a;
    end
    else if (prfn_hit(haddr_in, PRFN_OFS_FLAGS_B))
    begin
      rd_word[7:0] = peripheral_request_flags_b;
    end
    else if (prfn_hit(haddr_in, PRFN_OFS_CTRL_0))
    begin
      rd_word[PRFN_C0_POLARITY] = nmi_edge_polarity;
    end
    else if (prfn_hit(haddr_in, PRFN_OFS_CTRL_1))
    begin
      rd_word[PRFN_C1_REJECT]   = nmi_reject_bit;
      rd_word[PRFN_C1_OVERRIDE] = block_override_for_nmi;
    end
    else if (prfn_hit(haddr_in, PRFN_OFS_PRIO))
    begin
      rd_word[15:0] = prio;
    end
    else if (prfn_hit(haddr_in, PRFN_OFS_STATUS))
    begin
      rd_word[1:0]  = nmi_state;
      rd_word[6:2]  = best_level;
      rd_word[10:8] = best_class;
    end
  end

  // read data is taken in the address phase so it stands from a flop
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      hrdata_out <= 32'h00000000;
    end
    else if (addr_phase && !hwrite_in)
    begin
      hrdata_out <= rd_word;
    end
  end

  // ****************************************************************
  // nmi edge detection
  // ****************************************************************
  // a level counts only once seen on two edges in a row; shorter
  // pulses are filtered, which is why the driver must hold two cycles
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      nmi_s1     <= 1'b0;
      nmi_s2     <= 1'b0;
      nmi_stable <= 1'b0;
    end
    else
    begin
      nmi_s1 <= nmi_pin_in;
      nmi_s2 <= nmi_s1;
      if (nmi_s1 == nmi_s2)
      begin
        nmi_stable <= nmi_s2;
      end
    end
  end

  // polarity 1 selects rising, 0 falling
  assign nmi_edge = (nmi_s1 == nmi_s2) && (nmi_s2 != nmi_stable) &&
                    (nmi_s2 == nmi_edge_polarity);

  // reject wins; sleep and standby bypass the block bit
  assign nmi_acceptable = !nmi_reject_bit &&
                          (block_override_for_nmi ||
                           !cpu_status_in.status_block_bit || low_power);

  // ****************************************************************
  // nmi request state
  // ****************************************************************
  always_comb
  begin
    next_nmi_state = nmi_state;
    unique case (nmi_state)
      PRFN_NMI_IDLE:
      begin
        if (nmi_edge)
        begin
          next_nmi_state = PRFN_NMI_PENDING;
        end
      end
      PRFN_NMI_PENDING:
      begin
        if (cpu_ack_in && nmi_request_out)
        begin
          next_nmi_state = nmi_edge ? PRFN_NMI_PENDING : PRFN_NMI_TAKEN;
        end
      end
      PRFN_NMI_TAKEN:
      begin
        // a new edge in the cycle after the ack is kept pending, not lost
        next_nmi_state = nmi_edge ? PRFN_NMI_PENDING : PRFN_NMI_IDLE;
      end
      default:
      begin
        next_nmi_state = PRFN_NMI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      nmi_state <= PRFN_NMI_IDLE;
    end
    else
    begin
      nmi_state <= next_nmi_state;
    end
  end

  // ****************************************************************
  // priority resolution
  // ****************************************************************
  always_comb
  begin
    lvl_irq  = prfn_gate_level(1'b1, ext_levels_in.irq_level);
    lvl_enc  = prfn_gate_level(1'b1, ext_levels_in.enc_level);
    lvl_port = prfn_gate_level(1'b1, ext_levels_in.port_level);
    lvl_per  = PRFN_LVL_NONE;
    if (prfn_gate_level(periph_req_in.serial_c_tx || periph_req_in.serial_c_rx ||
                        periph_req_in.serial_c_error, prio[15:12]) > lvl_per)
    begin
      lvl_per = {1'b0, prio[15:12]};
    end
    if (prfn_gate_level(periph_req_in.adc_done, prio[11:8]) > lvl_per)
    begin
      lvl_per = {1'b0, prio[11:8]};
    end
    if (prfn_gate_level(|periph_req_in.dma_end, prio[7:4]) > lvl_per)
    begin
      lvl_per = {1'b0, prio[7:4]};
    end
    if (prfn_gate_level(periph_req_in.serial_a_tx || periph_req_in.serial_a_rx ||
                        periph_req_in.serial_a_error, prio[3:0]) > lvl_per)
    begin
      lvl_per = {1'b0, prio[3:0]};
    end
  end

  // ties go to the class checked last, nmi over the rest
  always_comb
  begin
    best_level = PRFN_LVL_NONE;
    best_class = PRFN_SRC_NONE;
    if (lvl_per > best_level)
    begin
      best_level = lvl_per;
      best_class = PRFN_SRC_PERIPH;
    end
    if (lvl_port >= best_level && lvl_port != PRFN_LVL_NONE)
    begin
      best_level = lvl_port;
      best_class = PRFN_SRC_PORT;
    end
    if (lvl_enc >= best_level && lvl_enc != PRFN_LVL_NONE)
    begin
      best_level = lvl_enc;
      best_class = PRFN_SRC_ENC;
    end
    if (lvl_irq >= best_level && lvl_irq != PRFN_LVL_NONE)
    begin
      best_level = lvl_irq;
      best_class = PRFN_SRC_IRQ;
    end
    if (nmi_state == PRFN_NMI_PENDING && nmi_acceptable)
    begin
      best_level = PRFN_LVL_NMI;
      best_class = PRFN_SRC_NMI;
    end
  end

  // ****************************************************************
  // cpu outputs
  // ****************************************************************
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      int_req_out        <= 1'b0;
      int_level_out      <= PRFN_LVL_NONE;
      int_class_out      <= PRFN_SRC_NONE;
      nmi_request_out    <= 1'b0;
      exc_mask_level_out <= 4'h0;
      wake_out           <= 1'b0;
    end
    else
    begin
      nmi_request_out <= (next_nmi_state == PRFN_NMI_PENDING) && nmi_acceptable;
      int_req_out     <= (best_class == PRFN_SRC_NMI) ||
                         (best_level > {1'b0, cpu_status_in.mask_level_bits});
      int_level_out   <= best_level;
      int_class_out   <= best_class;
      // no source rewrites the mask level on exception entry
      exc_mask_level_out <= cpu_status_in.mask_level_bits;
      wake_out        <= nmi_edge && low_power;
    end
  end

endmodule : prfn_top

// File: tb/prfn_cpu_model.sv
/*
  Behavioural cpu core that takes non-maskable requests by pulsing ack.
  Assumes clk_in and reset_in shared with prfn_top.
*/
`timescale 1ns/1ps
module prfn_cpu_model
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       nmi_request_in,
  input  wire logic [3:0] ack_delay_in,
  output logic            cpu_ack_out,
  output logic [7:0]      acks_out
);
  logic [3:0] wait_cnt;
  logic [1:0] hold;

  // ****************************************
  // ack after a chosen delay
  // ****************************************
  // hold-off stops a second ack while the request is still falling
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in)
    begin
      cpu_ack_out <= 1'b0;
      acks_out    <= 8'h00;
      wait_cnt    <= 4'h0;
      hold        <= 2'h0;
    end
    else
    begin
      cpu_ack_out <= 1'b0;
      if (hold != 2'h0)
        hold <= hold - 2'h1;
      else if (nmi_request_in && !cpu_ack_out)
      begin
        if (wait_cnt >= ack_delay_in)
        begin
          cpu_ack_out <= 1'b1;
          acks_out    <= acks_out + 8'h01;
          wait_cnt    <= 4'h0;
          hold        <= 2'h3;
        end
        else
          wait_cnt <= wait_cnt + 4'h1;
      end
    end
endmodule : prfn_cpu_model

// File: tb/prfn_top_asserts.sv
/*
  Concurrent checks on the ports of prfn_top.
  Assumes one clock and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module prfn_top_asserts
  import prfn_pkg::*;
(
  input wire logic             clk_in,
  input wire logic             reset_in,
  input wire logic             hsel_in,
  input wire logic [31:0]      haddr_in,
  input wire logic [1:0]       htrans_in,
  input wire logic             hwrite_in,
  input wire logic             hready_in,
  input wire logic             hreadyout_out,
  input wire logic             hresp_out,
  input wire logic [31:0]      hrdata_out,
  input wire prfn_periph_req_t periph_req_in,
  input wire logic             nmi_pin_in,
  input wire prfn_cpu_status_t cpu_status_in,
  input wire logic             int_req_out,
  input wire logic [4:0]       int_level_out,
  input wire prfn_class_t      int_class_out,
  input wire logic             nmi_request_out,
  input wire logic [3:0]       exc_mask_level_out,
  input wire logic             wake_out
);
  logic rd_a;
  logic rd_b;
  logic rd_go;

  assign rd_go = hsel_in & htrans_in[1] & hready_in & !hwrite_in;

  // ****************************************
  // read tracking
  // ****************************************
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in)
    begin
      rd_a <= 1'b0;
      rd_b <= 1'b0;
    end
    else
    begin
      rd_a <= rd_go && haddr_in == {24'h0, PRFN_OFS_FLAGS_A};
      rd_b <= rd_go && haddr_in == {24'h0, PRFN_OFS_FLAGS_B};
    end

  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // ****************************************
  // properties
  // ****************************************
  a_bus_okay: assert property (hreadyout_out && !hresp_out)
    else $error("bus not ready or not okay");
  a_flags_a: assert property (rd_a && !$past(reset_in, 2) |-> hrdata_out ==
    {24'h0, $past(periph_req_in.serial_a_tx, 2), 1'b0, $past(periph_req_in.serial_a_rx, 2),
     $past(periph_req_in.serial_a_error, 2), $past(periph_req_in.dma_end, 2)})
    else $error("flags a read wrong");
  a_flags_b: assert property (rd_b && !$past(reset_in, 2) |-> hrdata_out ==
    {27'h0, $past(periph_req_in.adc_done, 2), $past(periph_req_in.serial_c_tx, 2), 1'b0,
     $past(periph_req_in.serial_c_rx, 2), $past(periph_req_in.serial_c_error, 2)})
    else $error("flags b read wrong");
  a_nmi_top: assert property (int_class_out == PRFN_SRC_NMI |-> int_level_out == PRFN_LVL_NMI)
    else $error("nmi level not top");
  a_nmi_class: assert property ($rose(nmi_request_out) |-> ##[0:1] int_class_out == PRFN_SRC_NMI)
    else $error("nmi request without nmi class");
  a_level_range: assert property (int_level_out <= PRFN_LVL_NMI)
    else $error("level above top");
  a_masked_quiet: assert property (int_req_out |-> int_level_out != PRFN_LVL_NONE)
    else $error("request at level zero");
  a_mask_kept: assert property (nmi_request_out |->
    exc_mask_level_out == $past(cpu_status_in.mask_level_bits))
    else $error("mask level changed by nmi");
  a_wake_once: assert property (wake_out |=> !wake_out)
    else $error("wake longer than one cycle");
  a_wake_mode: assert property (wake_out |->
    $past(cpu_status_in.sleep | cpu_status_in.standby))
    else $error("wake outside sleep or standby");
  a_wake_filter: assert property (wake_out |-> $past(nmi_pin_in, 2) == $past(nmi_pin_in, 3))
    else $error("wake on unstable pin");
endmodule : prfn_top_asserts

bind prfn_top prfn_top_asserts u_asserts (.clk_in(clk_in), .reset_in(reset_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hready_in(hready_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .hrdata_out(hrdata_out), .periph_req_in(periph_req_in), .nmi_pin_in(nmi_pin_in),
  .cpu_status_in(cpu_status_in), .int_req_out(int_req_out), .int_level_out(int_level_out),
  .int_class_out(int_class_out), .nmi_request_out(nmi_request_out),
  .exc_mask_level_out(exc_mask_level_out), .wake_out(wake_out));

// File: tb/prfn_top_tb.sv
/*
  Self-checking bench for prfn_top: register reads over the bus,
  priority outputs and the nmi path against a cpu model.
  Assumes the package constants and a zero-wait slave.
*/
`timescale 1ns/1ps
module prfn_top_tb
  import prfn_pkg::*;
  ;
  logic             clk_in, reset_in, hsel, hwrite, nmi_pin, cpu_ack;
  logic             hreadyout, hresp, int_req, nmi_req, wake;
  logic [31:0]      haddr, hwdata, hrdata;
  logic [1:0]       htrans;
  logic [4:0]       int_level;
  logic [3:0]       exc_mask, ack_delay;
  logic [7:0]       acks;
  prfn_class_t      int_class;
  prfn_periph_req_t req, r;
  prfn_ext_levels_t ext;
  prfn_cpu_status_t st;
  int               miscompares = 0, checks_done = 0, cycles = 0, wakes = 0;
  logic [11:0]      ext_tab [4] = '{12'h000, 12'h006, 12'h086, 12'h986};
  logic [4:0]       lvl_tab [4] = '{5'h05, 5'h06, 5'h08, 5'h09};
  prfn_class_t      cls_tab [4] = '{PRFN_SRC_PERIPH, PRFN_SRC_PORT, PRFN_SRC_ENC, PRFN_SRC_IRQ};

  prfn_top DUT (.clk_in(clk_in), .reset_in(reset_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hreadyout_out(hreadyout), .hresp_out(hresp), .hrdata_out(hrdata),
    .periph_req_in(req), .ext_levels_in(ext), .nmi_pin_in(nmi_pin), .cpu_status_in(st),
    .cpu_ack_in(cpu_ack), .int_req_out(int_req), .int_level_out(int_level),
    .int_class_out(int_class), .nmi_request_out(nmi_req), .exc_mask_level_out(exc_mask),
    .wake_out(wake));

  prfn_cpu_model u_cpu (.clk_in(clk_in), .reset_in(reset_in), .nmi_request_in(nmi_req),
    .ack_delay_in(ack_delay), .cpu_ack_out(cpu_ack), .acks_out(acks));

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    if (wr)
      hwdata <= d;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask : rdc

  task automatic pin(input logic v, input int n);
    nmi_pin <= v;
    repeat (n) @(posedge clk_in);
  endtask : pin

  // an nmi counts as taken once the cpu model has acked it
  task automatic nmi_seen(input logic exp);
    logic [7:0] a0;
    a0 = acks;
    repeat (16) @(posedge clk_in);
    chk({31'h0, acks != a0}, {31'h0, exp});
  endtask : nmi_seen

  always @(posedge clk_in)
  begin
    if (wake === 1'b1)
      wakes++;
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      report_and_stop;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    reset_in = 1'b1;
    {hsel, hwrite, nmi_pin, htrans, haddr, hwdata} = '0;
    req = '0;
    ext = '0;
    st = '0;
    ack_delay = 4'h0;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    rdc(PRFN_OFS_FLAGS_A, 32'h0);
    rdc(PRFN_OFS_FLAGS_B, 32'h0);
    rdc(8'h40, 32'h0);
    for (int i = 0; i < 11; i++)
    begin
      r = prfn_periph_req_t'(11'h1 << i);
      req <= r;
      repeat (2) @(posedge clk_in);
      rdc(PRFN_OFS_FLAGS_A, {24'h0, r.serial_a_tx, 1'b0, r.serial_a_rx, r.serial_a_error,
          r.dma_end});
      rdc(PRFN_OFS_FLAGS_B, {27'h0, r.adc_done, r.serial_c_tx, 1'b0, r.serial_c_rx,
          r.serial_c_error});
    end
    req <= 11'h7FF;
    wr(PRFN_OFS_FLAGS_A, 32'h0);
    wr(PRFN_OFS_FLAGS_B, 32'h0);
    rdc(PRFN_OFS_FLAGS_A, 32'hBF);
    rdc(PRFN_OFS_FLAGS_B, 32'h1B);
    req <= '0;
    repeat (2) @(posedge clk_in);
    rdc(PRFN_OFS_FLAGS_A, 32'h0);
    req.serial_a_tx <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk({31'h0, int_req}, 32'h0);
    wr(PRFN_OFS_PRIO, 32'h1);
    repeat (3) @(posedge clk_in);
    chk(32'({int_req, int_level}), 32'h21);
    st.mask_level_bits <= 4'h2;
    wr(PRFN_OFS_PRIO, 32'h5);
    for (int i = 0; i < 4; i++)
    begin
      ext <= ext_tab[i];
      repeat (3) @(posedge clk_in);
      chk(32'({int_req, int_class, int_level}), 32'({1'b1, cls_tab[i], lvl_tab[i]}));
    end
    req <= '0;
    ext <= '0;
    wr(PRFN_OFS_CTRL_0, 32'h1);
    pin(1'b1, 3);
    pin(1'b0, 1);
    nmi_seen(1'b1);
    chk({28'h0, exc_mask}, 32'h2);
    pin(1'b1, 1);
    pin(1'b0, 1);
    nmi_seen(1'b0);
    wr(PRFN_OFS_CTRL_0, 32'h0);
    pin(1'b1, 3);
    nmi_seen(1'b0);
    pin(1'b0, 3);
    nmi_seen(1'b1);
    wr(PRFN_OFS_CTRL_0, 32'h1);
    ack_delay <= 4'h3;
    st.status_block_bit <= 1'b1;
    pin(1'b1, 3);
    pin(1'b0, 1);
    nmi_seen(1'b0);
    wr(PRFN_OFS_CTRL_1, 32'h2);
    nmi_seen(1'b1);
    st.status_block_bit <= 1'b0;
    wr(PRFN_OFS_CTRL_1, 32'h3);
    pin(1'b1, 3);
    pin(1'b0, 1);
    nmi_seen(1'b0);
    wr(PRFN_OFS_CTRL_1, 32'h0);
    nmi_seen(1'b1);
    st.status_block_bit <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      st.sleep <= (i == 0);
      st.standby <= (i == 1);
      pin(1'b1, 2);
      pin(1'b0, 1);
      nmi_seen(1'b1);
      chk(wakes, i + 1);
    end
    report_and_stop;
  end
endmodule : prfn_top_tb
